// ===== bench/fcw_flash_model.sv
// behavioural model of the bulk-erase flash behind the host
`timescale 1ns/1ps
module fcw_flash_model
  import fcw_pkg::*;
#(
  parameter logic [7:0] MAKER_CODE = 8'h3C, // arbitrary value
  parameter logic [7:0] PART_CODE  = 8'h5A  // arbitrary value
) (
  // flash pins
  input  wire fcw_ctl_t          i_ctl,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic              i_id_hv,
  input  wire logic [7:0]        i_dq,
  input  wire logic              i_supply,
  // fault control: cells refuse to change
  input  wire logic              i_stuck,
  output logic [7:0]             o_dq
);
  logic [7:0]        mem [0:(1<<ADDR_W)-1];
  logic [7:0]        cmd = CMD_READ;
  logic [ADDR_W-1:0] wa;
  logic [ADDR_W-1:0] va;
  logic [7:0]        val;
  logic [7:0]        last = 8'h00;
  wire logic         gate = i_ctl.ce_n | i_ctl.we_n;
  wire logic         drive = !i_ctl.ce_n && !i_ctl.oe_n;
  wire logic [7:0]   idc = i_addr[0] ? PART_CODE : MAKER_CODE;
  initial foreach (mem[i]) mem[i] = ERASED_BYTE;
  // supply coming up restores the read code
  always @(posedge i_supply) cmd = CMD_READ;
  // address on the later fall of strobe or select
  always @(negedge gate) if (i_ctl.oe_n) wa = i_addr;
  // data on the earlier rise; a single write never alters the array
  always @(posedge gate) begin
    if (!i_supply) cmd = CMD_READ;
    else if (i_ctl.oe_n) begin
      if (cmd == CMD_PROG) begin
        if (!i_stuck) mem[wa] = mem[wa] & i_dq;
        va = wa;
        cmd = 8'h01;
      end else if (cmd == CMD_ERASE && i_dq == CMD_ERASE) begin
        if (!i_stuck) foreach (mem[i]) mem[i] = ERASED_BYTE;
        cmd = 8'h02;
      end else begin
        if (i_dq == CMD_ERASE_VFY) va = wa;
        cmd = i_dq;
      end
    end
  end
  // read path: rom with supply low, command-dependent otherwise
  always @* begin
    if (!i_supply) val = i_id_hv ? idc : mem[i_addr];
    else if (cmd == 8'h90 || cmd == 8'h80) val = idc;
    else if (cmd == CMD_PROG_VFY || cmd == CMD_ERASE_VFY) val = mem[va];
    else val = mem[i_addr];
  end
  always @* if (drive) last = val;
  // released bus shows the inverse, so a stale sample cannot pass
  assign o_dq = drive ? val : ~last;
endmodule

// ===== bench/fcw_host_checker.sv
// assertions on the flash pins of the host controller
`timescale 1ns/1ps
module fcw_host_checker
  import fcw_pkg::*;
(
  // clock and reset
  input wire logic              I_REF_CLK,
  input wire logic              I_RST,
  // watched ports
  input wire logic              I_SUPPLY_HIGH,
  input wire logic              O_BUSY,
  input wire logic              O_DONE,
  input wire fcw_ctl_t          O_CTL,
  input wire logic [ADDR_W-1:0] O_ADDR,
  input wire logic              O_ID_HV,
  input wire logic [7:0]        O_DQ,
  input wire logic              O_DQ_OE_N
);
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (I_RST);
  // supply goes through two flops, so look three edges back
  supply_gate_a: assert property ($fell(O_CTL.we_n) |-> $past(I_SUPPLY_HIGH, 3))
    else $error("write strobe while supply low");
  strobe_len_a: assert property ($fell(O_CTL.we_n) |-> !O_CTL.we_n [*4] ##1 O_CTL.we_n)
    else $error("strobe low time wrong");
  data_hold_a: assert property (!O_CTL.we_n && $past(!O_CTL.we_n) |-> $stable(O_DQ) && $stable(O_ADDR) && !O_DQ_OE_N)
    else $error("address or data moved under strobe");
  write_frame_a: assert property (!O_CTL.we_n |-> O_CTL.oe_n && !O_CTL.ce_n)
    else $error("strobe low outside a legal frame");
  no_clash_a: assert property (!O_CTL.oe_n |-> O_DQ_OE_N)
    else $error("host drives data during a read");
  ident_addr_a: assert property (O_ID_HV |-> O_ADDR[ADDR_W-1:1] == '0)
    else $error("upper address lines high in identifier mode");
  idle_quiet_a: assert property (!O_BUSY && !O_DONE && $past(!O_BUSY) |-> O_CTL.we_n && O_DQ_OE_N)
    else $error("pins active while idle");
  done_once_a: assert property (O_DONE |-> $past(O_BUSY) ##1 !O_DONE)
    else $error("done not a single pulse after busy");
endmodule
bind fcw_host fcw_host_checker u_chk (.I_REF_CLK(I_REF_CLK), .I_RST(I_RST), .I_SUPPLY_HIGH(I_SUPPLY_HIGH),
  .O_BUSY(O_BUSY), .O_DONE(O_DONE), .O_CTL(O_CTL), .O_ADDR(O_ADDR), .O_ID_HV(O_ID_HV), .O_DQ(O_DQ),
  .O_DQ_OE_N(O_DQ_OE_N));

// ===== bench/tb_flash_command_write_interface.sv
// self-checking bench for the flash command write host controller
`timescale 1ns/1ps
module tb_flash_command_write_interface
  import fcw_pkg::*;
();
  typedef struct packed {
    fcw_op_t op; logic [ADDR_W-1:0] addr; logic [7:0] wd; logic sup; logic [7:0] rd; logic ckr; logic fail;
  } fcw_row_t;
  localparam logic [7:0] MK = 8'h3C;
  localparam logic [7:0] PT = 8'h5A;
  logic clk = 0, rst = 1, start = 0, sup = 0, stuck = 0;
  fcw_op_t op = OP_NONE;
  logic [ADDR_W-1:0] addr = '0, fa;
  logic [7:0] wd = '0, rdata, dq, flash_q;
  logic busy, done, fail, hv, dq_oe_n;
  fcw_ctl_t ctl;
  int err_total = 0, n_checks = 0, vfy_cnt = 0;
  // ordinary cases, run in order so the array state carries over
  fcw_row_t rows [8] = '{
    '{OP_READ,  17'h00005, 8'h00, 1'b0, 8'hFF, 1'b1, 1'b0},
    '{OP_PROG,  17'h00005, 8'h3C, 1'b1, 8'h3C, 1'b1, 1'b0},
    '{OP_READ,  17'h00005, 8'h00, 1'b1, 8'h3C, 1'b1, 1'b0},
    '{OP_PROG,  17'h00007, 8'hA5, 1'b0, 8'h00, 1'b0, 1'b1},
    '{OP_READ,  17'h00007, 8'h00, 1'b0, 8'hFF, 1'b1, 1'b0},
    '{OP_IDENT, 17'h00000, 8'h00, 1'b0, MK,    1'b1, 1'b0},
    '{OP_IDENT, 17'h00001, 8'h00, 1'b1, PT,    1'b1, 1'b0},
    '{OP_ERASE, 17'h00000, 8'h00, 1'b0, 8'h00, 1'b0, 1'b1}};

  fcw_host #(.ERASE_CYCLES(20)) DUT (.I_REF_CLK(clk), .I_RST(rst), .I_START(start), .I_OP(op), .I_ADDR(addr),
    .I_WDATA(wd), .I_SUPPLY_HIGH(sup), .O_BUSY(busy), .O_DONE(done), .O_FAIL(fail), .O_RDATA(rdata),
    .O_CTL(ctl), .O_ADDR(fa), .O_ID_HV(hv), .O_DQ(dq), .O_DQ_OE_N(dq_oe_n), .I_DQ(flash_q));
  fcw_flash_model #(.MAKER_CODE(MK), .PART_CODE(PT)) u_flash (.i_ctl(ctl), .i_addr(fa), .i_id_hv(hv),
    .i_dq(dq), .i_supply(sup), .i_stuck(stuck), .o_dq(flash_q));

  initial forever #12.5 clk = ~clk;
  // count program verify commands by the strobe edge that latches them
  always @(posedge ctl.we_n) if (dq === CMD_PROG_VFY) vfy_cnt++;

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, seen, exp);
    end
  endtask

  // supply settles through the synchroniser before the request
  task automatic run_op(input fcw_op_t o, input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic s);
    int n;
    @(posedge clk) sup <= s;
    repeat (4) @(posedge clk);
    op <= o; addr <= a; wd <= d; start <= 1'b1;
    @(posedge clk) start <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (done !== 1'b1 && n < 20000);
    if (n >= 20000) err_total++;
  endtask

  task conclude();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // watchdog: rows plus 25 program attempts fit well inside this
  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    conclude();
  end

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      run_op(rows[i].op, rows[i].addr, rows[i].wd, rows[i].sup);
      check(8'(fail), 8'(rows[i].fail), "fail flag");
      if (rows[i].ckr) check(rdata, rows[i].rd, "read data");
      $display("row %0d finished", i);
    end
    // cells that never take: retries stop at the cap
    stuck <= 1'b1;
    vfy_cnt = 0;
    run_op(OP_PROG, 17'h00009, 8'h00, 1'b1);
    check(8'(fail), 8'h01, "retry cap fail");
    check(8'(vfy_cnt), 8'(PROG_TRIES), "verify count");
    stuck <= 1'b0;
    $display("retry test finished");
    // reset in mid-operation parks the control pins and data enable and drops busy
    @(posedge clk) op <= OP_PROG;
    start <= 1'b1;
    @(posedge clk) start <= 1'b0;
    repeat (10) @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    #1 check(8'({ctl, dq_oe_n, busy}), 8'h1E, "pins in reset");
    @(posedge clk) rst <= 1'b0;
    $display("reset test finished");
    conclude();
  end
endmodule

// ===== verilog/fcw_host.sv
// host controller driving a bulk-erase flash through its parallel pins
`timescale 1ns/1ps
module fcw_host
  import fcw_pkg::*;
#(
  parameter int ERASE_CYCLES = ERASE_CYC
) (
  // clock and reset
  input  wire logic              I_REF_CLK,
  input  wire logic              I_RST,
  // request side
  input  wire logic              I_START,
  input  wire fcw_op_t           I_OP,
  input  wire logic [ADDR_W-1:0] I_ADDR,
  input  wire logic [7:0]        I_WDATA,
  input  wire logic              I_SUPPLY_HIGH,
  output logic                   O_BUSY,
  output logic                   O_DONE,
  output logic                   O_FAIL,
  output logic [7:0]             O_RDATA,
  // flash pins
  output fcw_ctl_t               O_CTL,
  output logic [ADDR_W-1:0]      O_ADDR,
  output logic                   O_ID_HV,
  output logic [7:0]             O_DQ,
  output logic                   O_DQ_OE_N,
  input  wire logic [7:0]        I_DQ
);

  fcw_st_t           st_q;
  fcw_op_t           op_q;
  logic [23:0]       cnt_q;
  logic [9:0]        tries_q;
  logic [2:0]        step_q;
  logic [ADDR_W-1:0] addr_q;
  logic [ADDR_W-1:0] cur_q;
  logic [7:0]        data_q;
  logic [7:0]        wd_q;
  logic [7:0]        dq_s1_q;
  logic [7:0]        dq_s2_q;
  logic              sup_s1_q;
  logic              sup_s2_q;

  // pin inputs cross into the clock domain through two flops
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      dq_s1_q  <= 8'h00;
      dq_s2_q  <= 8'h00;
      sup_s1_q <= 1'b0;
      sup_s2_q <= 1'b0;
    end else begin
      dq_s1_q  <= I_DQ;
      dq_s2_q  <= dq_s1_q;
      sup_s1_q <= I_SUPPLY_HIGH;
      sup_s2_q <= sup_s1_q;
    end
  end

  // command byte for a given step of the current operation
  function automatic logic [7:0] step_data(input fcw_op_t op, input logic [2:0] s, input logic [7:0] wd);
    logic [7:0] r;
    r = CMD_READ;
    case (op)
      OP_PROG:  r = (s == 3'h0) ? CMD_PROG : (s == 3'h1) ? wd : CMD_PROG_VFY;
      OP_ERASE: r = (s == 3'h2) ? CMD_ERASE_VFY : CMD_ERASE;
      OP_IDENT: r = 8'h90;
      default:  r = CMD_READ;
    endcase
    return r;
  endfunction

  // main sequencer: write cycles, pulse timing, verify reads and retries
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      st_q      <= ST_IDLE;
      op_q      <= OP_NONE;
      cnt_q     <= 24'h000000;
      tries_q   <= 10'h000;
      step_q    <= 3'h0;
      addr_q    <= '0;
      cur_q     <= '0;
      data_q    <= 8'h00;
      wd_q      <= 8'h00;
      O_CTL     <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
      O_ADDR    <= '0;
      O_ID_HV   <= 1'b0;
      O_DQ      <= 8'h00;
      O_DQ_OE_N <= 1'b1;
      O_BUSY    <= 1'b0;
      O_DONE    <= 1'b0;
      O_FAIL    <= 1'b0;
      O_RDATA   <= 8'h00;
    end else begin
      O_DONE <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          if (I_START) begin
            op_q    <= I_OP;
            addr_q  <= I_ADDR;
            wd_q    <= I_WDATA;
            tries_q <= 10'h000;
            step_q  <= 3'h0;
            cur_q   <= (I_OP == OP_ERASE) ? '0 : I_ADDR;
            O_BUSY  <= 1'b1;
            O_FAIL  <= 1'b0;
            cnt_q   <= PHASE_CYC;
            // with supply high a read first writes the read code, so a stale verify or identifier command cannot answer
            if (!sup_s2_q && (I_OP == OP_READ || I_OP == OP_IDENT)) begin
              st_q <= ST_RSET;
            end else if (!sup_s2_q) begin
              st_q <= ST_DONE;
              O_FAIL <= 1'b1;
            end else begin
              st_q <= ST_WSET;
            end
            O_ID_HV <= (I_OP == OP_IDENT) && !sup_s2_q;
            O_ADDR  <= (I_OP == OP_IDENT) ? {{(ADDR_W-1){1'b0}}, I_ADDR[0]} : I_ADDR;
          end
        end
        ST_WSET: begin
          // ce low first so the strobe frames the write; oe held high throughout
          O_CTL     <= '{ce_n: 1'b0, oe_n: 1'b1, we_n: 1'b1};
          O_DQ      <= step_data(op_q, step_q, wd_q);
          O_DQ_OE_N <= 1'b0;
          O_ADDR    <= (op_q == OP_ERASE && step_q == 3'h2) || op_q == OP_PROG ? cur_q : O_ADDR;
          cnt_q     <= cnt_q - 24'h000001;
          if (cnt_q == 24'h000001) begin
            st_q  <= ST_WLOW;
            cnt_q <= PHASE_CYC;
          end
        end
        ST_WLOW: begin
          // strobe low long enough to clear the glitch filter; address latched on fall
          O_CTL <= '{ce_n: 1'b0, oe_n: 1'b1, we_n: 1'b0};
          cnt_q <= cnt_q - 24'h000001;
          if (cnt_q == 24'h000001) begin
            st_q  <= ST_WHI;
            cnt_q <= PHASE_CYC;
          end
        end
        ST_WHI: begin
          // data latched on strobe rise; ce released on the same edge, so strobe and select rise together
          O_CTL <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
          cnt_q <= cnt_q - 24'h000001;
          if (cnt_q == 24'h000001) begin
            O_DQ_OE_N <= 1'b1;
            cnt_q     <= PHASE_CYC;
            st_q      <= ST_WSET;
            case (op_q)
              OP_PROG: begin
                step_q <= step_q + 3'h1;
                if (step_q == 3'h1) begin
                  st_q  <= ST_WAIT;
                  cnt_q <= 24'(PROG_CYC);
                end else if (step_q == 3'h2) begin
                  st_q <= ST_RSET;
                end
              end
              OP_ERASE: begin
                step_q <= step_q + 3'h1;
                if (step_q == 3'h1) begin
                  st_q  <= ST_WAIT;
                  cnt_q <= 24'(ERASE_CYCLES);
                end else if (step_q == 3'h2) begin
                  st_q <= ST_RSET;
                end
              end
              default: st_q <= ST_RSET;
            endcase
          end
        end
        ST_WAIT: begin
          cnt_q <= cnt_q - 24'h000001;
          if (cnt_q == 24'h000001) begin
            st_q  <= ST_WSET;
            cnt_q <= PHASE_CYC;
          end
        end
        ST_RSET: begin
          O_CTL     <= '{ce_n: 1'b0, oe_n: 1'b0, we_n: 1'b1};
          O_DQ_OE_N <= 1'b1;
          cnt_q     <= cnt_q - 24'h000001;
          if (cnt_q == 24'h000001) begin
            st_q  <= ST_RLOW;
            cnt_q <= 24'h000003;
          end
        end
        ST_RLOW: begin
          // wait out two synchroniser stages before sampling the data bus
          cnt_q <= cnt_q - 24'h000001;
          if (cnt_q == 24'h000001) begin
            data_q <= dq_s2_q;
            O_CTL  <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
            st_q   <= ST_CHK;
          end
        end
        ST_CHK: begin
          O_RDATA <= data_q;
          cnt_q   <= PHASE_CYC;
          st_q    <= ST_DONE;
          step_q  <= 3'h0;
          if (op_q == OP_ERASE) begin
            if (data_q == ERASED_BYTE) begin
              if (cur_q == LAST_ADDR) begin
                st_q <= ST_DONE;
              end else begin
                cur_q  <= cur_q + 17'h00001;
                step_q <= 3'h2;
                st_q   <= ST_WSET;
              end
            end else if (tries_q == 10'(ERASE_TRIES - 1)) begin
              O_FAIL <= 1'b1;
            end else begin
              tries_q <= tries_q + 10'h001;
              st_q    <= ST_WSET;
            end
          end else if (op_q == OP_PROG && data_q != wd_q) begin
            if (tries_q == 10'(PROG_TRIES - 1)) begin
              O_FAIL <= 1'b1;
            end else begin
              tries_q <= tries_q + 10'h001;
              st_q    <= ST_WSET;
            end
          end
        end
        ST_DONE: begin
          // drop the identifier voltage and end busy; no read code is written, so the flash keeps its last command
          O_ID_HV  <= 1'b0;
          O_BUSY   <= 1'b0;
          O_DONE   <= 1'b1;
          st_q     <= ST_IDLE;
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

endmodule

// ===== verilog/fcw_pkg.sv
// package for the flash command write host controller
package fcw_pkg;
  localparam int CLK_MHZ       = 40;
  localparam int ADDR_W        = 17;
  localparam logic [7:0] CMD_READ      = 8'h00;
  localparam logic [7:0] CMD_ERASE     = 8'h20;
  localparam logic [7:0] CMD_ERASE_VFY = 8'hA0;
  localparam logic [7:0] CMD_PROG      = 8'h40;
  localparam logic [7:0] CMD_PROG_VFY  = 8'hC0;
  localparam logic [7:0] ERASED_BYTE   = 8'hFF;
  localparam logic [7:0] ZERO_BYTE     = 8'h00;
  localparam int ERASE_PULSE_MS = 10;
  localparam int PROG_PULSE_US  = 10;
  localparam int ERASE_CYC      = ERASE_PULSE_MS * 1000 * CLK_MHZ;
  localparam int PROG_CYC       = PROG_PULSE_US * CLK_MHZ;
  localparam int ERASE_TRIES    = 1000;
  localparam int PROG_TRIES     = 25;
  // bus phase lengths, 4 cycles = 100 ns, well over glitch filter and access time
  localparam logic [23:0] PHASE_CYC = 24'h000004;
  localparam logic [ADDR_W-1:0] LAST_ADDR = 17'h1FFFF;
  localparam logic [ADDR_W-1:0] ID_ADDR = 17'h00000;

  typedef enum logic [2:0] {
    OP_NONE  = 3'h0,
    OP_READ  = 3'h1,
    OP_PROG  = 3'h2,
    OP_ERASE = 3'h3,
    OP_IDENT = 3'h4
  } fcw_op_t;

  typedef struct packed {
    logic              ce_n;
    logic              oe_n;
    logic              we_n;
  } fcw_ctl_t;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0000,
    ST_WSET  = 4'b0001,
    ST_WLOW  = 4'b0011,
    ST_WHI   = 4'b0010,
    ST_WAIT  = 4'b0110,
    ST_RSET  = 4'b0111,
    ST_RLOW  = 4'b0101,
    ST_CHK   = 4'b0100,
    ST_DONE  = 4'b1100
  } fcw_st_t;
endpackage
